// File: pkg/uptc_pkg.sv
// Purpose: constants and carriers for the usb phy test and control register bank
// Assumes: 32-bit avalon-mm slave with byte addresses, single clock
// Notes: reserved bits read zero
// Overview of operation
// R1: read-only pll clocks usable status, bit 12
// R2: read/write ss transmit pll enable, bit 11
// R3: read-only ss transmit pll usable, bit 10
// R4: bit 9 set disables frontend ready timer
// R5: bit 0 forces all clock gating bypass
// R6: lpm default from eeprom, else otp, else 0
// R7: lpm image flag chosen by hs/fs mode
// R8: usb/lite reset reloads lpm image or 0
// R9: bit 22 fs driver enable, active low
// R10: bits 21/20 fs levels on dp/dm
// R11: read-only fs differential receiver result, bit 19
// R12: hs valid mask 00/01/11; 10 is stored but driven as 00
// R13: hs transmit bits sent serially, lsb first
// R14: hs current source on, forced in hs mode
// R15: bits 10:8 select hs drive current level
// R16: drive level default eeprom, else otp, else 000
// R17: usb/lite reset restores eeprom drive level or 000
// R18: reset protection keeps programmed drive level
// R19: bits 7/6 enable 1.5k pull-ups
// R20: bits 5/4 enable 15k pull-downs
// R21: bit 1 hs driver idle or transmit
// R22: reserved bits read zero, writes ignored
package uptc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_COMMON = 8'h00;
    localparam logic [7:0] ADDR_AFE = 8'hc4;
    localparam logic [7:0] ADDR_GUARD = 8'h10;
    // common register fields
    localparam int COM_LPM_BIT = 17;
    localparam int COM_PLL_OK_BIT = 12;
    localparam int COM_SS_ON_BIT = 11;
    localparam int COM_SS_OK_BIT = 10;
    localparam int COM_TIMER_OFF_BIT = 9;
    localparam int COM_BYPASS_BIT = 0;
    // frontend register fields
    localparam int AFE_FS_OE_N_BIT = 22;
    localparam int AFE_FS_PLUS_BIT = 21;
    localparam int AFE_FS_MINUS_BIT = 20;
    localparam int AFE_FS_RX_BIT = 19;
    localparam int AFE_VALID_LSB = 14;
    localparam int AFE_BITS_LSB = 12;
    localparam int AFE_CS_BIT = 11;
    localparam int AFE_LEVEL_LSB = 8;
    localparam int AFE_PU_PLUS_BIT = 7;
    localparam int AFE_PU_MINUS_BIT = 6;
    localparam int AFE_PD_PLUS_BIT = 5;
    localparam int AFE_PD_MINUS_BIT = 4;
    localparam int AFE_HS_TX_BIT = 1;
    // guard register field
    localparam int GUARD_PROTECT_BIT = 0;
    // valid mask codes, reset values and synchroniser width
    localparam logic [1:0] VALID_NONE = 2'h0;
    localparam logic [1:0] VALID_LSB = 2'h1;
    localparam logic [1:0] VALID_BAD = 2'h2;
    localparam logic [1:0] VALID_BOTH = 2'h3;
    localparam logic [2:0] LEVEL_NOMINAL = 3'h0;
    localparam logic LPM_DEFAULT = 1'b0;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
    localparam int SYNC_W = 3;

    typedef struct packed {
        logic lpm;
        logic ss_on;
        logic timer_off;
        logic bypass;
    } uptc_com_t;

    typedef struct packed {
        logic fs_oe_n;
        logic fs_plus;
        logic fs_minus;
        logic [1:0] valid;
        logic [1:0] bits;
        logic cs_on;
        logic [2:0] level;
        logic pu_plus;
        logic pu_minus;
        logic pd_plus;
        logic pd_minus;
        logic hs_tx;
    } uptc_afe_t;

    typedef struct packed {
        logic eeprom_present;
        logic otp_programmed;
        logic lpm_hs;
        logic lpm_fs;
        logic [2:0] level;
    } uptc_image_t;

    localparam uptc_com_t COM_RESET = '{lpm: LPM_DEFAULT, ss_on: 1'b0, timer_off: 1'b0, bypass: 1'b0};
    localparam uptc_afe_t AFE_RESET = '{fs_oe_n: 1'b0, fs_plus: 1'b0, fs_minus: 1'b0, valid: VALID_NONE,
        bits: 2'h0, cs_on: 1'b0, level: LEVEL_NOMINAL, pu_plus: 1'b0, pu_minus: 1'b0, pd_plus: 1'b0,
        pd_minus: 1'b0, hs_tx: 1'b0};
endpackage : uptc_pkg

// File: src/uptc_sync.sv
// Purpose: three-stage synchroniser with agreement filter for status pins
// Assumes: inputs are asynchronous to clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/100ps
module uptc_sync
#(
    parameter int W = 3
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] level_ff;
    logic [W-1:0] agree;
    logic [W-1:0] nxt_level;

    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_level = (agree & s3_ff) | (~agree & level_ff);
    assign level_out = level_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            level_ff <= '0;
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= nxt_level;
        end
    end
endmodule : uptc_sync

// File: src/uptc_regs.sv
// Purpose: usb phy test and control registers behind an avalon-mm slave
// Assumes: status pins asynchronous; config image, mode and reset strobes on clk
// Notes: every access answers one cycle after it is seen
`timescale 1ns/100ps
module uptc_regs
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cfg_load,
    input wire uptc_pkg::uptc_image_t cfg_image,
    input wire logic hs_mode,
    input wire logic usb_reset,
    input wire logic lite_reset,
    input wire logic pll_clocks_ok_pin,
    input wire logic ss_tx_pll_ok_pin,
    input wire logic fs_rx_diff_pin,
    output logic ss_tx_pll_on,
    output logic frontend_ready_timer_off,
    output logic gating_bypass_force,
    output logic lpm_fast_start,
    output logic fs_driver_oe_n,
    output logic fs_plus_out,
    output logic fs_minus_out,
    output logic [1:0] frontend_hs_valid_bus,
    output logic hs_tx_serial,
    output logic hs_tx_serial_valid,
    output logic hs_current_source_on,
    output logic [2:0] drive_current_level,
    output logic pullup_plus_on,
    output logic pullup_minus_on,
    output logic pulldown_plus_on,
    output logic pulldown_minus_on,
    output logic hs_driver_transmit
);
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
        input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    function automatic logic lpm_from_image(input uptc_pkg::uptc_image_t img, input logic hs);
        logic v;
        v = hs ? img.lpm_hs : img.lpm_fs;
        if (!(img.eeprom_present || img.otp_programmed))
        begin
            v = uptc_pkg::LPM_DEFAULT;
        end
        return v;
    endfunction : lpm_from_image

    uptc_pkg::uptc_com_t com_ff;
    uptc_pkg::uptc_com_t nxt_com;
    uptc_pkg::uptc_afe_t afe_ff;
    uptc_pkg::uptc_afe_t nxt_afe;
    uptc_pkg::uptc_image_t image_ff;
    uptc_pkg::uptc_image_t nxt_image;
    logic guard_ff;
    logic nxt_guard;
    logic waitrequest_ff;
    logic nxt_waitrequest;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic [2:0] status_sync;
    logic pll_ok;
    logic ss_ok;
    logic fs_rx;
    logic req;
    logic accept;
    logic wr_now;
    logic sel_com;
    logic sel_afe;
    logic sel_guard;
    logic restore;
    logic [31:0] com_view;
    logic [31:0] afe_view;
    logic [31:0] guard_view;
    logic [31:0] com_wr;
    logic [31:0] afe_wr;
    logic [31:0] guard_wr;
    logic [2:0] boost_image;
    logic [2:0] boost_restore;
    logic tx_phase_ff;
    logic nxt_tx_phase;
    logic tx_bit_ff;
    logic tx_valid_ff;
    logic nxt_tx_bit;
    logic nxt_tx_valid;
    logic tx_go;
    logic [1:0] valid_bus_ff;
    logic [1:0] nxt_valid_bus;
    logic cs_ff;
    logic nxt_cs;

    // asynchronous analogue status inputs
    uptc_sync #(.W(uptc_pkg::SYNC_W)) u_status_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({pll_clocks_ok_pin, ss_tx_pll_ok_pin, fs_rx_diff_pin}),
        .level_out(status_sync)
    );

    assign pll_ok = status_sync[2];
    assign ss_ok = status_sync[1];
    assign fs_rx = status_sync[0];

    // bus decode
    assign req = avs_read || avs_write;
    assign accept = req && waitrequest_ff;
    assign wr_now = avs_write && !waitrequest_ff;
    assign sel_com = (avs_address == uptc_pkg::ADDR_COMMON);
    assign sel_afe = (avs_address == uptc_pkg::ADDR_AFE);
    assign sel_guard = (avs_address == uptc_pkg::ADDR_GUARD);
    assign restore = usb_reset || lite_reset;

    // read views, reserved bits zero
    always_comb
    begin
        com_view = uptc_pkg::RDATA_NONE; // see R22
        com_view[uptc_pkg::COM_LPM_BIT] = com_ff.lpm;
        com_view[uptc_pkg::COM_PLL_OK_BIT] = pll_ok; // see R1
        com_view[uptc_pkg::COM_SS_ON_BIT] = com_ff.ss_on;
        com_view[uptc_pkg::COM_SS_OK_BIT] = ss_ok; // see R3
        com_view[uptc_pkg::COM_TIMER_OFF_BIT] = com_ff.timer_off;
        com_view[uptc_pkg::COM_BYPASS_BIT] = com_ff.bypass;
    end

    always_comb
    begin
        afe_view = uptc_pkg::RDATA_NONE; // see R22
        afe_view[uptc_pkg::AFE_FS_OE_N_BIT] = afe_ff.fs_oe_n;
        afe_view[uptc_pkg::AFE_FS_PLUS_BIT] = afe_ff.fs_plus;
        afe_view[uptc_pkg::AFE_FS_MINUS_BIT] = afe_ff.fs_minus;
        afe_view[uptc_pkg::AFE_FS_RX_BIT] = fs_rx; // see R11
        afe_view[uptc_pkg::AFE_VALID_LSB +: 2] = afe_ff.valid;
        afe_view[uptc_pkg::AFE_BITS_LSB +: 2] = afe_ff.bits;
        afe_view[uptc_pkg::AFE_CS_BIT] = cs_ff; // see R14
        afe_view[uptc_pkg::AFE_LEVEL_LSB +: 3] = afe_ff.level;
        afe_view[uptc_pkg::AFE_PU_PLUS_BIT] = afe_ff.pu_plus;
        afe_view[uptc_pkg::AFE_PU_MINUS_BIT] = afe_ff.pu_minus;
        afe_view[uptc_pkg::AFE_PD_PLUS_BIT] = afe_ff.pd_plus;
        afe_view[uptc_pkg::AFE_PD_MINUS_BIT] = afe_ff.pd_minus;
        afe_view[uptc_pkg::AFE_HS_TX_BIT] = afe_ff.hs_tx;
    end

    always_comb
    begin
        guard_view = uptc_pkg::RDATA_NONE;
        guard_view[uptc_pkg::GUARD_PROTECT_BIT] = guard_ff;
    end

    assign com_wr = merge_bytes(com_view, avs_writedata, avs_byteenable);
    assign afe_wr = merge_bytes(afe_view, avs_writedata, avs_byteenable);
    assign guard_wr = merge_bytes(guard_view, avs_writedata, avs_byteenable);

    // drive level defaults and restore values
    assign boost_image = (cfg_image.eeprom_present || cfg_image.otp_programmed) ? cfg_image.level
        : uptc_pkg::LEVEL_NOMINAL; // see R16
    assign boost_restore = image_ff.eeprom_present ? image_ff.level : uptc_pkg::LEVEL_NOMINAL; // see R17

    // bus handshake: one wait cycle, answer on the next
    always_comb
    begin
        nxt_waitrequest = 1'b1;
        nxt_readdata = readdata_ff;
        if (accept)
        begin
            nxt_waitrequest = 1'b0;
            nxt_readdata = uptc_pkg::RDATA_NONE;
            if (avs_read && sel_com)
            begin
                nxt_readdata = com_view;
            end
            else if (avs_read && sel_afe)
            begin
                nxt_readdata = afe_view;
            end
            else if (avs_read && sel_guard)
            begin
                nxt_readdata = guard_view;
            end
        end
    end

    // common register next state
    always_comb
    begin
        nxt_com = com_ff;
        if (wr_now && sel_com)
        begin
            nxt_com.lpm = com_wr[uptc_pkg::COM_LPM_BIT];
            nxt_com.ss_on = com_wr[uptc_pkg::COM_SS_ON_BIT]; // see R2
            nxt_com.timer_off = com_wr[uptc_pkg::COM_TIMER_OFF_BIT]; // see R4
            nxt_com.bypass = com_wr[uptc_pkg::COM_BYPASS_BIT]; // see R5
        end
        if (cfg_load)
        begin
            nxt_com.lpm = lpm_from_image(cfg_image, hs_mode); // see R6 R7
        end
        else if (restore)
        begin
            nxt_com.lpm = lpm_from_image(image_ff, hs_mode); // see R8
        end
    end

    // frontend register next state
    always_comb
    begin
        nxt_afe = afe_ff;
        if (wr_now && sel_afe)
        begin
            nxt_afe.fs_oe_n = afe_wr[uptc_pkg::AFE_FS_OE_N_BIT]; // see R9
            nxt_afe.fs_plus = afe_wr[uptc_pkg::AFE_FS_PLUS_BIT]; // see R10
            nxt_afe.fs_minus = afe_wr[uptc_pkg::AFE_FS_MINUS_BIT]; // see R10
            nxt_afe.valid = afe_wr[uptc_pkg::AFE_VALID_LSB +: 2]; // see R12
            nxt_afe.bits = afe_wr[uptc_pkg::AFE_BITS_LSB +: 2];
            nxt_afe.cs_on = afe_wr[uptc_pkg::AFE_CS_BIT];
            nxt_afe.level = afe_wr[uptc_pkg::AFE_LEVEL_LSB +: 3]; // see R15
            nxt_afe.pu_plus = afe_wr[uptc_pkg::AFE_PU_PLUS_BIT]; // see R19
            nxt_afe.pu_minus = afe_wr[uptc_pkg::AFE_PU_MINUS_BIT]; // see R19
            nxt_afe.pd_plus = afe_wr[uptc_pkg::AFE_PD_PLUS_BIT]; // see R20
            nxt_afe.pd_minus = afe_wr[uptc_pkg::AFE_PD_MINUS_BIT]; // see R20
            nxt_afe.hs_tx = afe_wr[uptc_pkg::AFE_HS_TX_BIT]; // see R21
        end
        if (cfg_load)
        begin
            nxt_afe.level = boost_image; // see R16
        end
        else if (restore && !guard_ff)
        begin
            nxt_afe.level = boost_restore; // see R17 R18
        end
    end

    // image memory and guard
    always_comb
    begin
        nxt_image = image_ff;
        if (cfg_load)
        begin
            nxt_image = cfg_image;
        end
        nxt_guard = guard_ff;
        if (wr_now && sel_guard)
        begin
            nxt_guard = guard_wr[uptc_pkg::GUARD_PROTECT_BIT];
        end
    end

    // hs test transmitter, lsb first
    assign tx_go = afe_ff.hs_tx && ((afe_ff.valid == uptc_pkg::VALID_LSB) || (afe_ff.valid == uptc_pkg::VALID_BOTH));

    always_comb
    begin
        nxt_tx_phase = 1'b0;
        nxt_tx_bit = 1'b0;
        nxt_tx_valid = 1'b0;
        if (tx_go)
        begin
            nxt_tx_bit = (afe_ff.valid == uptc_pkg::VALID_BOTH) ? afe_ff.bits[tx_phase_ff] : afe_ff.bits[0]; // see R13
            nxt_tx_valid = 1'b1;
            nxt_tx_phase = (afe_ff.valid == uptc_pkg::VALID_BOTH) ? ~tx_phase_ff : 1'b0; // see R12 R13
        end
    end

    // code 10 is never driven to the frontend
    assign nxt_valid_bus = (afe_ff.valid == uptc_pkg::VALID_BAD) ? uptc_pkg::VALID_NONE : afe_ff.valid; // see R12
    assign nxt_cs = afe_ff.cs_on || hs_mode; // see R14

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            com_ff <= uptc_pkg::COM_RESET;
            afe_ff <= uptc_pkg::AFE_RESET;
            image_ff <= '0;
            guard_ff <= 1'b0;
        end
        else
        begin
            com_ff <= nxt_com;
            afe_ff <= nxt_afe;
            image_ff <= nxt_image;
            guard_ff <= nxt_guard;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waitrequest_ff <= 1'b1;
            readdata_ff <= uptc_pkg::RDATA_NONE;
        end
        else
        begin
            waitrequest_ff <= nxt_waitrequest;
            readdata_ff <= nxt_readdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_phase_ff <= 1'b0;
            tx_bit_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            valid_bus_ff <= uptc_pkg::VALID_NONE;
            cs_ff <= 1'b0;
        end
        else
        begin
            tx_phase_ff <= nxt_tx_phase;
            tx_bit_ff <= nxt_tx_bit;
            tx_valid_ff <= nxt_tx_valid;
            valid_bus_ff <= nxt_valid_bus;
            cs_ff <= nxt_cs;
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata = readdata_ff;
    assign avs_waitrequest = waitrequest_ff;
    assign ss_tx_pll_on = com_ff.ss_on; // see R2
    assign frontend_ready_timer_off = com_ff.timer_off; // see R4
    assign gating_bypass_force = com_ff.bypass; // see R5
    assign lpm_fast_start = com_ff.lpm;
    assign fs_driver_oe_n = afe_ff.fs_oe_n; // see R9
    assign fs_plus_out = afe_ff.fs_plus;
    assign fs_minus_out = afe_ff.fs_minus;
    assign frontend_hs_valid_bus = valid_bus_ff;
    assign hs_tx_serial = tx_bit_ff;
    assign hs_tx_serial_valid = tx_valid_ff;
    assign hs_current_source_on = cs_ff;
    assign drive_current_level = afe_ff.level; // see R15
    assign pullup_plus_on = afe_ff.pu_plus;
    assign pullup_minus_on = afe_ff.pu_minus;
    assign pulldown_plus_on = afe_ff.pd_plus;
    assign pulldown_minus_on = afe_ff.pd_minus;
    assign hs_driver_transmit = afe_ff.hs_tx; // see R21
endmodule : uptc_regs

// File: tb/uptc_regs_chk.sv
// Purpose: bus and field checks on uptc_regs ports
// Assumes: one clock domain, async active-high reset
// Notes: bound to every uptc_regs instance below
`timescale 1ns/100ps
module uptc_chk
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic hs_mode,
    input wire logic usb_reset,
    input wire logic lite_reset,
    input wire logic cfg_load,
    input wire logic lpm_fast_start,
    input wire logic [1:0] frontend_hs_valid_bus,
    input wire logic hs_tx_serial_valid,
    input wire logic hs_current_source_on,
    input wire logic [2:0] drive_current_level,
    input wire logic hs_driver_transmit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic req = (avs_read | avs_write) & avs_waitrequest;
    wire logic rd_com = req & avs_read & (avs_address == 8'h00);
    wire logic rd_afe = req & avs_read & (avs_address == 8'hc4);
    wire logic rd_un = req & avs_read & (avs_address != 8'h00) & (avs_address != 8'hc4) & (avs_address != 8'h10);
    wire logic strobe = avs_write | cfg_load | usb_reset | lite_reset;
    AST_ANSWER_NEXT: assert property (req |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    AST_ANSWER_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer stood longer than one cycle");
    AST_UNMAPPED_ZERO: assert property (rd_un |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_COM_RSV: assert property (rd_com |=> (avs_readdata & 32'hfffd_e1fe) == 32'h0)
        else $error("common reserved bits not zero");
    AST_AFE_RSV: assert property (rd_afe |=> (avs_readdata & 32'hff87_000d) == 32'h0)
        else $error("frontend reserved bits not zero");
    AST_HS_CS: assert property (hs_mode |=> hs_current_source_on)
        else $error("current source off in hs mode");
    AST_MASK_LEGAL: assert property (frontend_hs_valid_bus != 2'h2)
        else $error("illegal valid mask driven");
    AST_IDLE_NO_BITS: assert property (!hs_driver_transmit |=> !hs_tx_serial_valid)
        else $error("serial bits while driver idle");
    AST_NOMASK_NO_BITS: assert property (frontend_hs_valid_bus == 2'h0 |-> !hs_tx_serial_valid)
        else $error("serial bits with empty mask");
    AST_LPM_CAUSE: assert property (!$stable(lpm_fast_start) |-> $past(strobe))
        else $error("lpm bit changed without cause");
    AST_LEVEL_CAUSE: assert property (!$stable(drive_current_level) |-> $past(strobe))
        else $error("drive level changed without cause");
    cover property (rd_un);
    cover property (hs_tx_serial_valid && frontend_hs_valid_bus == 2'h3);
    cover property (usb_reset | lite_reset);
endmodule : uptc_chk

bind uptc_regs uptc_chk u_chk
(
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .hs_mode,
    .usb_reset, .lite_reset, .cfg_load, .lpm_fast_start, .frontend_hs_valid_bus, .hs_tx_serial_valid,
    .hs_current_source_on, .drive_current_level, .hs_driver_transmit
);

// File: tb/usb_phy_test_control_regs_tb.sv
// Purpose: self-checking bench for uptc_regs
// Assumes: avalon master tasks, reads noted in a queue
// Notes: a monitor compares read data as answers appear
`timescale 1ns/100ps
module usb_phy_test_control_regs_tb;
    logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, cfg_load, hs_mode, usb_reset, lite_reset, lpm;
    logic ss_tx_pll_on, frontend_ready_timer_off, gating_bypass_force, lpm_fast_start, fs_driver_oe_n;
    logic fs_plus_out, fs_minus_out, hs_tx_serial, hs_tx_serial_valid, hs_current_source_on;
    logic pullup_plus_on, pullup_minus_on, pulldown_plus_on, pulldown_minus_on, hs_driver_transmit;
    logic [1:0] frontend_hs_valid_bus;
    logic [2:0] drive_current_level, pins;
    logic [3:0] avs_byteenable;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, r, d, m;
    logic [31:0] exp_q[$], msk_q[$];
    uptc_pkg::uptc_image_t cfg_image, img;
    int n_fail, tests_run, seed, i;
    wire logic [3:0] com_o = {lpm_fast_start, ss_tx_pll_on, frontend_ready_timer_off, gating_bypass_force};
    wire logic [13:0] afe_o = {fs_driver_oe_n, fs_plus_out, fs_minus_out, frontend_hs_valid_bus,
        hs_current_source_on, drive_current_level, pullup_plus_on, pullup_minus_on, pulldown_plus_on,
        pulldown_minus_on, hs_driver_transmit};

    uptc_regs DUT
    (
        .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .cfg_load, .cfg_image, .hs_mode, .usb_reset, .lite_reset,
        .pll_clocks_ok_pin(pins[2]), .ss_tx_pll_ok_pin(pins[1]), .fs_rx_diff_pin(pins[0]),
        .ss_tx_pll_on, .frontend_ready_timer_off, .gating_bypass_force, .lpm_fast_start, .fs_driver_oe_n,
        .fs_plus_out, .fs_minus_out, .frontend_hs_valid_bus, .hs_tx_serial, .hs_tx_serial_valid,
        .hs_current_source_on, .drive_current_level, .pullup_plus_on, .pullup_minus_on, .pulldown_plus_on,
        .pulldown_minus_on, .hs_driver_transmit
    );

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= dt;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        bus(1'b1, a, dt, 4'hf);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    task automatic strobe(input logic [2:0] s);
        {cfg_load, usb_reset, lite_reset} <= s;
        step(1);
        {cfg_load, usb_reset, lite_reset} <= 3'h0;
        step(1);
    endtask : strobe

    task automatic ser(input logic [3:0] e);
        int k;
        while (hs_tx_serial_valid !== 1'b1)
            @(posedge clk);
        for (k = 0; k < 4; k++)
        begin
            chk("serial", 32'(e[k]), 32'(hs_tx_serial));
            @(posedge clk);
        end
    endtask : ser

    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // read answers are compared oldest note first
    always @(posedge clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
        begin
            m = msk_q.pop_front();
            chk("readdata", exp_q.pop_front() & m, avs_readdata & m);
        end
    end

    initial
    begin
        step(20000);
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end

    initial
    begin
        seed = 32'h2017eb63;
        {avs_read, avs_write, cfg_load, usb_reset, lite_reset, hs_mode} = 6'h0;
        avs_address = 8'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        cfg_image = '0;
        pins = 3'h0;
        sys_rst = 1'b1;
        step(8);
        sys_rst <= 1'b0;
        step(1);
        rd(8'h00, 32'h0, 32'hffff_ffff);
        rd(8'hc4, 32'h0, 32'hffff_ffff);
        $display("test reset values done");
        wr(8'h00, 32'hffff_ffff);
        chk("com_out", 32'hf, 32'(com_o));
        rd(8'h00, 32'h0002_0a01, 32'hffff_ffff);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0, 32'hffff_ffff);
        sys_rst <= 1'b1;
        step(2);
        sys_rst <= 1'b0;
        step(1);
        chk("com_out", 32'h0, 32'(com_o));
        rd(8'h00, 32'h0, 32'hffff_ffff);
        $display("test common register done");
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            pins <= r[2:0];
            step(6);
            rd(8'h00, {19'h0, pins[2], 1'b0, pins[1], 10'h0}, 32'h0000_1400);
            rd(8'hc4, {12'h0, pins[0], 19'h0}, 32'h0008_0000);
        end
        $display("test status pins done");
        for (i = 0; i < 8; i++)
        begin
            d = $random(seed);
            d[10:8] = i[2:0];
            d[15:14] = (i == 3) ? 2'h2 : ((d[15:14] == 2'h2) ? 2'h1 : d[15:14]);
            wr(8'hc4, d);
            step(1);
            chk("afe_out", {18'h0, d[22:20], ((d[15:14] == 2'h2) ? 2'h0 : d[15:14]), d[11:4], d[1]},
                {18'h0, afe_o});
            rd(8'hc4, d, 32'h0070_fff2);
        end
        bus(1'b1, 8'hc4, 32'h0, 4'h2);
        rd(8'hc4, d & 32'hffff_00ff, 32'h0070_fff2);
        $display("test frontend register done");
        wr(8'hc4, 32'h0000_e002);
        step(1);
        ser(4'b1010);
        wr(8'hc4, 32'h0000_5002);
        step(1);
        ser(4'b1111);
        wr(8'hc4, 32'h0000_3002);
        step(2);
        chk("serial_valid", 32'h0, 32'(hs_tx_serial_valid));
        wr(8'hc4, 32'h0);
        hs_mode <= 1'b1;
        step(2);
        chk("cs_on", 32'h1, 32'(hs_current_source_on));
        rd(8'hc4, 32'h0000_0800, 32'h0000_0800);
        $display("test hs transmit done");
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            img = r[6:0];
            img.eeprom_present = i[1];
            img.otp_programmed = i[0];
            hs_mode <= r[7];
            cfg_image <= img;
            strobe(3'h4);
            lpm = (i != 0) && (r[7] ? img.lpm_hs : img.lpm_fs);
            chk("lpm", 32'(lpm), 32'(lpm_fast_start));
            chk("level", (i != 0) ? 32'(img.level) : 32'h0, 32'(drive_current_level));
            wr(8'h00, {14'h0, !lpm, 17'h0});
            wr(8'hc4, {21'h0, ~img.level, 8'h0});
            strobe(r[8] ? 3'h2 : 3'h1);
            chk("lpm", 32'(lpm), 32'(lpm_fast_start));
            chk("level", i[1] ? 32'(img.level) : 32'h0, 32'(drive_current_level));
        end
        wr(8'h10, 32'h1);
        wr(8'hc4, 32'h0000_0500);
        strobe(3'h2);
        chk("level", 32'h5, 32'(drive_current_level));
        wr(8'h10, 32'h0);
        hs_mode <= 1'b0;
        $display("test image and restore done");
        report_and_stop();
    end
endmodule : usb_phy_test_control_regs_tb
